// File: shared/alarm_irq_pkg.sv
package alarm_irq_pkg;
	// Register offsets within one channel's byte-wide register space.
	localparam logic [11:0] STATUS_ADDR = 12'hB02;
	localparam logic [11:0] ENABLE_ADDR = 12'hB03;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// Writable enable bits: 3..0; bit 4 and 7..5 hold no state.
	localparam logic [7:0] ENABLE_MASK = 8'h0F;
	localparam int CODE_VIOL_BIT = 3;
	localparam int FRAME_LOSS_BIT = 2;
	localparam int ALL_ONES_BIT = 1;
	localparam int REMOTE_ALARM_BIT = 0;
endpackage

// File: verilog/t1_alarm_error_irq_enable.sv
// Operation
// RULE_01 - Bits 7..5 unused in T1, read zero.
// RULE_02 - Software writes zero to bit 4.
// RULE_03 - Bit 3 enables line code violation interrupt.
// RULE_04 - Bit 2 enables interrupt on frame-loss declare.
// RULE_05 - Bit 2 also covers frame-loss clear.
// RULE_06 - Bit 1 enables all-ones alarm change interrupt.
// RULE_07 - Bit 0 enables remote alarm change interrupt.
// RULE_08 - Status flags latch, clear on status read.
// RULE_09 - Interrupt is OR of enabled latched flags.
`timescale 1ns/1ns
`default_nettype none
module t1_alarm_error_irq_enable (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic line_code_violation_in,
	input wire logic frame_loss_state_in,
	input wire logic all_ones_alarm_state_in,
	input wire logic remote_alarm_state_in,
	output logic irq_out
);
	logic [3:0] enable_q, enable_d;
	logic [3:0] status_q, status_d;
	logic [2:0] state_q, state_d;
	logic [7:0] rdata_q, rdata_d;
	logic [3:0] event_w;
	logic status_rd_w;
	logic status_wr_w;
	logic enable_wr_w;

	// Address decode is shared by next-state logic and checks, so it lives here once.
	function automatic logic hits_enable(input logic [11:0] addr);
		return addr == alarm_irq_pkg::ENABLE_ADDR;
	endfunction

	function automatic logic hits_status(input logic [11:0] addr);
		return addr == alarm_irq_pkg::STATUS_ADDR;
	endfunction

	// Only the low nibble of a written byte carries enables or clear requests.
	function automatic logic [3:0] low_nibble(input logic [7:0] data);
		return data[3:0];
	endfunction

	// Alarm changes are edges in either direction of the defect states.
	// The stored copy resets low, so an alarm already up at release is reported once.
	always_comb begin
		state_d = {frame_loss_state_in, all_ones_alarm_state_in, remote_alarm_state_in};
		event_w[alarm_irq_pkg::CODE_VIOL_BIT] = line_code_violation_in;
		event_w[alarm_irq_pkg::FRAME_LOSS_BIT] = state_d[2] ^ state_q[2]; // RULE_04 RULE_05
		event_w[alarm_irq_pkg::ALL_ONES_BIT] = state_d[1] ^ state_q[1];
		event_w[alarm_irq_pkg::REMOTE_ALARM_BIT] = state_d[0] ^ state_q[0];
	end

	always_comb begin
		status_rd_w = reg_rd_in && hits_status(reg_addr_in);
		status_wr_w = reg_wr_in && hits_status(reg_addr_in);
		enable_wr_w = reg_wr_in && hits_enable(reg_addr_in);
		enable_d = enable_q;
		if (enable_wr_w) begin
			// Bit 4 and the E1-only bits are not stored, so they always read back as zero.
			enable_d = low_nibble(reg_wdata_in); // RULE_01 RULE_03 RULE_06 RULE_07
		end
		status_d = status_q;
		if (status_rd_w) begin
			status_d = 4'h0; // RULE_08
		end
		if (status_wr_w) begin
			status_d = status_d & ~low_nibble(reg_wdata_in);
		end
		// A new event in the clearing cycle is kept so it is never lost.
		status_d = status_d | event_w; // RULE_08
		rdata_d = 8'h00;
		if (reg_rd_in) begin
			if (hits_enable(reg_addr_in)) begin
				rdata_d = {4'h0, enable_q}; // RULE_01
			end else if (hits_status(reg_addr_in)) begin
				rdata_d = {4'h0, status_q};
			end
		end
	end

	// Each group of state has its own register process; all share the one reset.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			enable_q <= alarm_irq_pkg::ENABLE_RESET[3:0];
		end else begin
			enable_q <= enable_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_q <= alarm_irq_pkg::STATUS_RESET[3:0];
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= 3'h0;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	// Registered flags and enables only, so the request line carries no decode glitches.
	assign irq_out = |(status_q & enable_q); // RULE_09

	// The checks below watch only what this block drives or decodes.
	chk_irq_from_flags: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_09
		irq_out == |(status_q & enable_q))
		else $error("interrupt not OR of enabled flags");

	chk_lcv_latches: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_03
		line_code_violation_in |=> status_q[3])
		else $error("line code violation flag not latched");

	chk_oof_edges: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_05
		(frame_loss_state_in != state_q[2]) |=> status_q[2])
		else $error("frame loss change not latched");

	chk_ais_edges: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_06
		(all_ones_alarm_state_in != state_q[1]) |=> status_q[1])
		else $error("all-ones change not latched");

	chk_yel_edges: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_07
		(remote_alarm_state_in != state_q[0]) |=> status_q[0])
		else $error("remote alarm change not latched");

	chk_read_clears: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_08
		(status_rd_w && event_w == 4'h0) |=> status_q == 4'h0)
		else $error("status read did not clear flags");

	chk_read_data: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_08
		status_rd_w |=> reg_rdata_out == {4'h0, $past(status_q)})
		else $error("status read data wrong");

	chk_enable_store: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_03
		enable_wr_w |=> enable_q == $past(reg_wdata_in[3:0]))
		else $error("enable write not stored");

	chk_upper_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_01
		reg_rdata_out[7:4] == 4'h0)
		else $error("reserved bits not zero");

	chk_masked_quiet: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_04
		(enable_q == 4'h0) |-> !irq_out)
		else $error("interrupt with all enables clear");

	chk_w1c_clears: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_08
		(status_wr_w && event_w == 4'h0) |=> (status_q & $past(reg_wdata_in[3:0])) == 4'h0)
		else $error("written ones did not clear flags");

	chk_set_wins: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_08
		(status_rd_w && event_w != 4'h0) |=> status_q == $past(event_w))
		else $error("event lost in clearing cycle");

	chk_flags_sticky: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_08
		(!status_rd_w && !status_wr_w) |=> (status_q & $past(status_q)) == $past(status_q))
		else $error("flag dropped without clear");

	chk_no_spurious: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_08
		(!status_rd_w && !status_wr_w && event_w == 4'h0) |=> $stable(status_q))
		else $error("flag set without event");

	chk_enable_holds: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_03
		!enable_wr_w |=> $stable(enable_q))
		else $error("enable changed without write");

	chk_state_tracks: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_05
		1'b1 |=> state_q == $past(state_d))
		else $error("stored alarm state stale");

	chk_enable_readback: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_03
		(reg_rd_in && hits_enable(reg_addr_in)) |=> reg_rdata_out == {4'h0, $past(enable_q)})
		else $error("enable read data wrong");

	chk_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_01
		(reg_rd_in && !hits_enable(reg_addr_in) && !hits_status(reg_addr_in))
		|=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");

	chk_lcv_gated: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_03
		(status_q[3] && enable_q[3]) |-> irq_out)
		else $error("enabled violation flag without interrupt");

	chk_oof_gated: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_04
		(status_q[2] && enable_q[2]) |-> irq_out)
		else $error("enabled frame loss flag without interrupt");

	chk_ais_gated: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_06
		(status_q[1] && enable_q[1]) |-> irq_out)
		else $error("enabled all-ones flag without interrupt");

	chk_yel_gated: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_07
		(status_q[0] && enable_q[0]) |-> irq_out)
		else $error("enabled remote alarm flag without interrupt");

	chk_irq_drops: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // RULE_09
		(status_rd_w && event_w == 4'h0) |=> !irq_out)
		else $error("interrupt held after flags cleared");

	cov_irq_raise: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) $rose(irq_out));
	cov_irq_drop: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) $fell(irq_out));
	cov_set_on_read: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
		status_rd_w && event_w != 4'h0);
	cov_w1c: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
		status_wr_w && status_q != 4'h0);
	cov_frame_loss_clear: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
		$fell(frame_loss_state_in) && enable_q[2]);
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [11:0] ea = alarm_irq_pkg::ENABLE_ADDR;
	localparam logic [11:0] sa = alarm_irq_pkg::STATUS_ADDR;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic lcv = 1'b0;
	logic [2:0] st = 3'b000;
	logic [7:0] rdata;
	logic irq;
	int errors = 0;
	int tests_run = 0;
	always #2 sys_clk_in = ~sys_clk_in;
	t1_alarm_error_irq_enable i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .line_code_violation_in(lcv), .frame_loss_state_in(st[2]),
		.all_ones_alarm_state_in(st[1]), .remote_alarm_state_in(st[0]), .irq_out(irq));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a, input logic [7:0] exp);
		@(posedge sys_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk_in);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	// Alarm states are levels; the violation input is a one-cycle pulse.
	task automatic ev(input logic [2:0] s, input logic l, input logic [7:0] irq_exp);
		@(posedge sys_clk_in);
		st <= s;
		lcv <= l;
		@(posedge sys_clk_in);
		lcv <= 1'b0;
		#1 check({7'h00, irq}, irq_exp);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		rd_reg(ea, 8'h00);
		rd_reg(sa, 8'h00);
		wr_reg(ea, 8'hEF);
		rd_reg(ea, 8'h0F);
		rd_reg(12'hB05, 8'h00);
		ev(3'b000, 1'b1, 8'h01);
		rd_reg(sa, 8'h08);
		ev(3'b000, 1'b0, 8'h00);
		for (int b = 0; b < 3; b++) begin
			ev(3'b001 << b, 1'b0, 8'h01);
			rd_reg(sa, 8'h01 << b);
			ev(3'b000, 1'b0, 8'h01);
			rd_reg(sa, 8'h01 << b);
		end
		wr_reg(ea, 8'h0B);
		ev(3'b100, 1'b0, 8'h00);
		ev(3'b100, 1'b1, 8'h01);
		wr_reg(ea, 8'h00);
		ev(3'b100, 1'b0, 8'h00);
		rd_reg(sa, 8'h0C);
		ev(3'b000, 1'b0, 8'h00);
		wr_reg(ea, 8'h04);
		ev(3'b000, 1'b0, 8'h01);
		wr_reg(sa, 8'h04);
		rd_reg(sa, 8'h00);
		ev(3'b000, 1'b0, 8'h00);
		wr_reg(ea, 8'h0F);
		@(posedge sys_clk_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		rd_reg(ea, 8'h00);
		rd_reg(sa, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
